// ==== design/kpi_top.sv ====
/*
  Keypad programming-mode interpreter: entry, field commands, pages, exits, errors.
  Assumes key strobes synchronous to clk, one key per strobe, and a single clock.
*/
// Function
// RULE1 - Star and pound together within 30 s of power-up enter programming.
// RULE2 - Installer code then 8000 enters programming; code defaults 4140, set in field 0.
// RULE3 - Star plus two digits opens that field for writing.
// RULE4 - Pound plus two digits shows the field without changing it.
// RULE5 - A completed field gives three beeps and advances to the next.
// RULE6 - Star 91 prompts for and selects the partition to program.
// RULE7 - Star 92 shows the software revision.
// RULE8 - Star 93 switches into interactive menu mode.
// RULE9 - Star 94 moves up one field page, at most to page three.
// RULE10 - Star 99 steps back a page, or exits from page one without lockout.
// RULE11 - Star 98 exits and locks out installer-code re-entry.
// RULE12 - After star 99 exit, installer code plus 8000 still re-enters.
// RULE13 - Pages two and three show prefix 1 or 2 and a banner 100 or 200.
// RULE14 - On higher pages the installer keys star and only the last two digits.
// RULE15 - An invalid field address shows the address error indication.
// RULE16 - An out-of-range value blanks the display.
// RULE17 - After defaults load, only keypads 00 and 01 may program.
// RULE18 - When download disables local programming, refuse all keypad entry.
// RULE19 - Test standby battery 10 min every 4 h, first 4 h after exit.
// RULE20 - Entering test mode starts a battery test at once.
// RULE21 - Run a 5 s battery presence check every 60 s.
// RULE22 - Skip partition-specific fields on global pass unless one partition exists.
// RULE23 - After an entry error, wait for a new field command; store unchanged.
module kpi_top (
  input  wire logic        clk,            // Clock, 40 MHz.
  input  wire logic        reset_n,        // Asynchronous reset, active low.
  input  wire logic        key_valid,      // One-cycle key strobe.
  input  wire logic [3:0]  key_code,       // 0-9 digits, star, pound, both.
  input  wire logic [4:0]  key_addr,       // Address of the keypad sending the key.
  input  wire logic        local_prog_dis, // Local programming disabled by download.
  input  wire logic        test_entry,     // Pulse: test mode entered.
  input  wire logic        multi_part,     // More than one partition configured.
  input  wire logic [3:0]  part_field_max, // Highest BCD units digit of non-partition fields.
  output logic             prog_mode_ff,   // Programming mode active.
  output logic             menu_mode_ff,   // Interactive menu mode active.
  output logic [1:0]       page_ff,        // Current field page, 0 to 2.
  output logic [1:0]       page_prefix_ff, // Digit shown before field address.
  output logic             alt_banner_ff,  // Alternate page banner shown.
  output logic [7:0]       banner_num_ff,  // Banner number, BCD hundreds in [7:4].
  output logic [7:0]       field_ff,       // Current field address, BCD.
  output logic [2:0]       disp_ff,        // Display selection code.
  output logic [15:0]      disp_data_ff,   // Data shown on display.
  output logic [3:0]       part_ff,        // Selected partition.
  output logic             beep_ff,        // One-cycle beep pulse.
  output logic             inst_lock_ff,   // Installer-code entry locked out.
  output logic             long_test_ff,   // Long battery test running.
  output logic             pres_test_ff    // Battery presence check running.
);
  kpi_pkg::state_t state_ff, nxt_state;
  kpi_field_if fld ();

  logic [25:0] tick_ff;
  logic [4:0]  pwr_sec_ff;
  logic        pwr_win_ff;
  logic [15:0] inst_code_ff, sh_ff;
  logic [2:0]  cnt_ff;
  logic        is_write_ff, dflt_ff, exit_pulse_ff;
  logic [1:0]  beeps_ff;
  logic [7:0]  addr_ff;
  logic        wr_ff;
  logic [15:0] wdata_ff;

  function automatic logic is_digit(input logic [3:0] k);
    return k <= 4'h9;
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  wire sec_tick = tick_ff == 26'(kpi_pkg::TICK_CYCLES - 1);
  // RULE17 keypad address filter.
  wire kp_ok    = !dflt_ff || key_addr <= 5'h01;
  // RULE18 download lockout.
  wire kp_allow = kp_ok && !local_prog_dis;
  wire key_ok   = key_valid && kp_allow;
  wire dig      = key_ok && is_digit(key_code);
  wire star     = key_ok && key_code == kpi_pkg::KEY_STAR;
  wire pound    = key_ok && key_code == kpi_pkg::KEY_POUND;
  wire [7:0]  two   = {sh_ff[3:0], key_code};
  wire [15:0] four  = {sh_ff[11:0], key_code};
  wire        cmd   = two >= kpi_pkg::CMD_PART;
  // RULE15 address range check.
  wire addr_ok = (page_ff == 2'h0) ? two <= kpi_pkg::P0_MAX :
                 (page_ff == 2'h1) ? (two >= kpi_pkg::P1_MIN && two <= kpi_pkg::P1_MAX) :
                                     two <= kpi_pkg::P2_MAX;
  // RULE16 digit value range check.
  wire val_ok  = two[3:0] <= 4'h9;
  // RULE22 partition-specific fields sit above part_field_max in this layout.
  wire [7:0] inc_fld = bcd_inc(field_ff);
  wire is_part_fld = page_ff == 2'h0 && inc_fld[7:4] == 4'h0 &&
                     inc_fld[3:0] > part_field_max;
  wire [7:0] adv_fld = (multi_part && part_ff == 4'h0 && is_part_fld) ? 8'h10 : inc_fld;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff    <= 26'h0000000;
      pwr_sec_ff <= 5'h00;
      pwr_win_ff <= 1'b1;
    end else begin
      tick_ff <= sec_tick ? 26'h0000000 : tick_ff + 26'h0000001;
      // RULE1 power-up window.
      if (sec_tick && pwr_win_ff) begin
        pwr_sec_ff <= pwr_sec_ff + 5'h01;
        pwr_win_ff <= pwr_sec_ff != 5'(kpi_pkg::PWRUP_WIN_S - 1);
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      kpi_pkg::ST_IDLE: begin
        // RULE1 two-key entry.
        if (key_valid && kp_allow && key_code == kpi_pkg::KEY_BOTH && pwr_win_ff)
          nxt_state = kpi_pkg::ST_WAIT;
        // RULE12 code path stays open.
        else if (dig && kp_allow && !inst_lock_ff)
          nxt_state = kpi_pkg::ST_CODE;
      end
      kpi_pkg::ST_CODE: if (key_ok && !dig) nxt_state = kpi_pkg::ST_IDLE;
        else if (dig && cnt_ff == 3'h3)
          nxt_state = (four == inst_code_ff) ? kpi_pkg::ST_SEQ : kpi_pkg::ST_IDLE;
      kpi_pkg::ST_SEQ: if (key_ok && !dig) nxt_state = kpi_pkg::ST_IDLE;
        // RULE2 fixed 8000 suffix.
        else if (dig && cnt_ff == 3'h3)
          nxt_state = (four == kpi_pkg::ENTRY_SEQ) ? kpi_pkg::ST_WAIT : kpi_pkg::ST_IDLE;
      kpi_pkg::ST_WAIT: if (star || pound) nxt_state = kpi_pkg::ST_ADDR;
      kpi_pkg::ST_ADDR: if (key_ok && !dig) nxt_state = kpi_pkg::ST_WAIT;
        else if (dig && cnt_ff == 3'h1) begin
          if (cmd && is_write_ff)
            case (two)
              kpi_pkg::CMD_PART: nxt_state = kpi_pkg::ST_PARTN;
              kpi_pkg::CMD_MENU: nxt_state = kpi_pkg::ST_MENU;
              kpi_pkg::CMD_LOCK: nxt_state = kpi_pkg::ST_IDLE;
              kpi_pkg::CMD_BACK:
                nxt_state = (page_ff == 2'h0) ? kpi_pkg::ST_IDLE : kpi_pkg::ST_WAIT;
              default: nxt_state = kpi_pkg::ST_WAIT;
            endcase
          else if (addr_ok && is_write_ff) nxt_state = kpi_pkg::ST_DATA;
          else nxt_state = kpi_pkg::ST_WAIT;
        end
      kpi_pkg::ST_DATA: if (star || pound) nxt_state = kpi_pkg::ST_ADDR;
        // RULE23 errors return to waiting.
        else if (key_ok && !val_ok) nxt_state = kpi_pkg::ST_WAIT;
      kpi_pkg::ST_PARTN: if (dig) nxt_state = kpi_pkg::ST_WAIT;
      kpi_pkg::ST_MENU: if (pound) nxt_state = kpi_pkg::ST_WAIT;
      default: nxt_state = kpi_pkg::ST_IDLE;
    endcase
  end

  wire entering = state_ff != kpi_pkg::ST_WAIT && state_ff != kpi_pkg::ST_ADDR &&
                  state_ff != kpi_pkg::ST_DATA && state_ff != kpi_pkg::ST_PARTN &&
                  state_ff != kpi_pkg::ST_MENU && nxt_state == kpi_pkg::ST_WAIT;
  wire addr_done  = state_ff == kpi_pkg::ST_ADDR && dig && cnt_ff == 3'h1;
  wire data_dig   = state_ff == kpi_pkg::ST_DATA && dig;
  wire field_full = data_dig && cnt_ff == 3'(kpi_pkg::FIELD_DIGITS - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= kpi_pkg::ST_IDLE;
      sh_ff    <= 16'h0000;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      sh_ff    <= (dig && state_ff != nxt_state && state_ff != kpi_pkg::ST_IDLE) ? 16'h0000 :
                  dig ? four : sh_ff;
      cnt_ff   <= (state_ff == kpi_pkg::ST_IDLE) ? {2'h0, dig} :
                  (state_ff != nxt_state || field_full || star || pound) ? 3'h0 :
                  dig ? cnt_ff + 3'h1 : cnt_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_mode_ff  <= 1'b0;
      menu_mode_ff  <= 1'b0;
      inst_lock_ff  <= 1'b0;
      page_ff       <= 2'h0;
      part_ff       <= 4'h0;
      is_write_ff   <= 1'b1;
      dflt_ff       <= 1'b0;
      exit_pulse_ff <= 1'b0;
      field_ff      <= 8'h00;
      disp_ff       <= kpi_pkg::DISP_NORMAL;
      inst_code_ff  <= kpi_pkg::INST_CODE_RST;
      wr_ff         <= 1'b0;
      wdata_ff      <= 16'h0000;
      addr_ff       <= 8'h00;
      beeps_ff      <= 2'h0;
      beep_ff       <= 1'b0;
    end else begin
      exit_pulse_ff <= 1'b0;
      wr_ff         <= 1'b0;
      beep_ff       <= beeps_ff != 2'h0 && !beep_ff;
      if (beeps_ff != 2'h0 && beep_ff) beeps_ff <= beeps_ff - 2'h1;
      if (entering) begin
        prog_mode_ff <= 1'b1;
        page_ff      <= 2'h0;
        disp_ff      <= kpi_pkg::DISP_NORMAL;
      end
      // RULE3 star opens for write.
      if (nxt_state == kpi_pkg::ST_ADDR && star) is_write_ff <= 1'b1;
      // RULE4 pound is read only.
      if (nxt_state == kpi_pkg::ST_ADDR && pound) is_write_ff <= 1'b0;
      if (addr_done) begin
        field_ff <= two;
        disp_ff  <= kpi_pkg::DISP_NORMAL;
        if (cmd && is_write_ff)
          case (two)
            // RULE6 partition prompt.
            kpi_pkg::CMD_PART: disp_ff <= kpi_pkg::DISP_PART;
            // RULE7 revision display.
            kpi_pkg::CMD_REV:  disp_ff <= kpi_pkg::DISP_REV;
            // RULE8 menu mode.
            kpi_pkg::CMD_MENU: menu_mode_ff <= 1'b1;
            // RULE9 page up.
            kpi_pkg::CMD_NEXT: if (page_ff != 2'h2) page_ff <= page_ff + 2'h1;
            kpi_pkg::CMD_DFLT: dflt_ff <= 1'b1;
            // RULE11 exit with lockout.
            kpi_pkg::CMD_LOCK: begin
              prog_mode_ff  <= 1'b0;
              inst_lock_ff  <= 1'b1;
              page_ff       <= 2'h0;
              exit_pulse_ff <= 1'b1;
            end
            // RULE10 page back or exit.
            kpi_pkg::CMD_BACK: if (page_ff != 2'h0) page_ff <= page_ff - 2'h1;
              else begin
                prog_mode_ff  <= 1'b0;
                exit_pulse_ff <= 1'b1;
              end
            default: disp_ff <= kpi_pkg::DISP_ADDR_E;
          endcase
        // RULE15 address error shown.
        else if (!addr_ok) disp_ff <= kpi_pkg::DISP_ADDR_E;
        else if (!is_write_ff) disp_ff <= kpi_pkg::DISP_READ;
      end
      // RULE16 blank on bad value.
      if (state_ff == kpi_pkg::ST_DATA && key_ok && !val_ok && !star && !pound)
        disp_ff <= kpi_pkg::DISP_BLANK;
      if (state_ff == kpi_pkg::ST_PARTN && dig) begin
        part_ff <= key_code;
        disp_ff <= kpi_pkg::DISP_NORMAL;
      end
      if (state_ff == kpi_pkg::ST_MENU && pound) menu_mode_ff <= 1'b0;
      if (field_full) begin
        // RULE5 three beeps and advance.
        wr_ff    <= 1'b1;
        wdata_ff <= four;
        addr_ff  <= field_ff;
        beeps_ff <= kpi_pkg::BEEP_COUNT;
        field_ff <= adv_fld;
        // RULE2 code changed via field 0.
        if (page_ff == 2'h0 && field_ff == 8'h00) inst_code_ff <= four;
      end
    end
  end

  // RULE13 page prefix and banner.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_prefix_ff <= 2'h0;
      alt_banner_ff  <= 1'b0;
      banner_num_ff  <= 8'h00;
      disp_data_ff   <= 16'h0000;
    end else begin
      page_prefix_ff <= page_ff;
      alt_banner_ff  <= prog_mode_ff && page_ff != 2'h0;
      banner_num_ff  <= {2'h0, page_ff, 4'h0};
      disp_data_ff   <= (disp_ff == kpi_pkg::DISP_REV) ? {8'h00, kpi_pkg::SW_REV} :
                        (disp_ff == kpi_pkg::DISP_READ) ? fld.rdata : sh_ff;
    end
  end

  assign fld.wr_en = wr_ff;
  // Writes use the latched address, since field_ff has already moved on.
  assign fld.addr  = {page_ff, wr_ff ? addr_ff : field_ff};
  assign fld.wdata = wdata_ff;

  kpi_field_mem u_mem (
    .clk (clk),
    .fld (fld)
  );

  kpi_batt_sched u_batt (
    .clk          (clk),
    .reset_n      (reset_n),
    .sec_tick     (sec_tick),
    .prog_exit    (exit_pulse_ff),
    .test_entry   (test_entry),
    .long_test_ff (long_test_ff),
    .pres_test_ff (pres_test_ff)
  );
endmodule

// ==== design/kpi_pkg.sv ====
/*
  Shared constants and types for the keypad programming-mode interpreter.
  Assumes a 40 MHz clock and keys delivered as one-cycle strobes with a 4-bit code.
*/
package kpi_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned PWRUP_WIN_S   = 30;
  localparam int unsigned BATT_PERIOD_S = 14400;
  localparam int unsigned BATT_LONG_S   = 600;
  localparam int unsigned PRES_PERIOD_S = 60;
  localparam int unsigned PRES_LEN_S    = 5;
  localparam int unsigned TICK_CYCLES   = CLK_HZ;
  // Key codes.
  localparam logic [3:0] KEY_STAR  = 4'hA;
  localparam logic [3:0] KEY_POUND = 4'hB;
  localparam logic [3:0] KEY_BOTH  = 4'hC;
  // Defaults and fixed entry sequence.
  localparam logic [15:0] INST_CODE_RST = 16'h4140;
  localparam logic [15:0] ENTRY_SEQ     = 16'h8000;
  // Command field numbers (BCD).
  localparam logic [7:0] CMD_PART  = 8'h91;
  localparam logic [7:0] CMD_REV   = 8'h92;
  localparam logic [7:0] CMD_MENU  = 8'h93;
  localparam logic [7:0] CMD_NEXT  = 8'h94;
  localparam logic [7:0] CMD_DFLT  = 8'h97;
  localparam logic [7:0] CMD_LOCK  = 8'h98;
  localparam logic [7:0] CMD_BACK  = 8'h99;
  // Field address limits per page.
  localparam logic [7:0] P0_MAX = 8'h90;
  localparam logic [7:0] P1_MIN = 8'h01;
  localparam logic [7:0] P1_MAX = 8'h80;
  localparam logic [7:0] P2_MAX = 8'h24;
  localparam int unsigned FIELD_DIGITS = 4;
  localparam logic [1:0]  BEEP_COUNT   = 2'h3;
  // Display codes.
  localparam logic [2:0] DISP_NORMAL = 3'h0;
  localparam logic [2:0] DISP_ADDR_E = 3'h1;
  localparam logic [2:0] DISP_BLANK  = 3'h2;
  localparam logic [2:0] DISP_REV    = 3'h3;
  localparam logic [2:0] DISP_PART   = 3'h4;
  localparam logic [2:0] DISP_READ   = 3'h5;
  localparam logic [7:0] SW_REV      = 8'h01;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_CODE  = 8'b0000_0010,
    ST_WAIT  = 8'b0000_0100,
    ST_ADDR  = 8'b0000_1000,
    ST_DATA  = 8'b0001_0000,
    ST_PARTN = 8'b0010_0000,
    ST_MENU  = 8'b0100_0000,
    ST_SEQ   = 8'b1000_0000
  } state_t;
endpackage

// ==== design/kpi_field_if.sv ====
/*
  Carries field-store accesses from the interpreter to the field memory.
  Assumes one access per cycle at most.
*/
interface kpi_field_if;
  logic       wr_en;
  logic [9:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output wr_en, output addr, output wdata, input rdata);
  modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface

// ==== design/kpi_field_mem.sv ====
/*
  Field store, one 16-bit word per page/field address; registered read.
  Assumes the interpreter holds addr steady for one cycle before using rdata.
*/
module kpi_field_mem (
  input wire logic clk,     // Clock.
  kpi_field_if.mem fld      // Field access port.
);
  logic [15:0] mem [0:1023];
  logic [15:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (fld.wr_en) begin
      mem[fld.addr] <= fld.wdata;
    end
    rdata_ff <= mem[fld.addr];
  end

  assign fld.rdata = rdata_ff;
endmodule

// ==== design/kpi_batt_sched.sv ====
/*
  Standby battery test scheduler: long test every period, short presence check.
  Assumes a one-cycle second tick from the interpreter.
*/
module kpi_batt_sched (
  input  wire logic clk,          // Clock.
  input  wire logic reset_n,      // Asynchronous reset, active low.
  input  wire logic sec_tick,     // One-cycle pulse per second.
  input  wire logic prog_exit,    // Pulse on leaving programming mode.
  input  wire logic test_entry,   // Pulse on entering test mode.
  output logic      long_test_ff, // Long battery load test running.
  output logic      pres_test_ff  // Presence check running.
);
  logic        armed_ff;
  logic [13:0] period_ff;
  logic [9:0]  long_ff;
  logic [5:0]  pres_ff;
  wire         period_done = armed_ff && sec_tick &&
                             period_ff == 14'(kpi_pkg::BATT_PERIOD_S - 1);
  wire         long_done   = sec_tick && long_ff == 10'(kpi_pkg::BATT_LONG_S - 1);

  // RULE19 period and duration.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_ff  <= 1'b0;
      period_ff <= 14'h0000;
    end else if (prog_exit) begin
      armed_ff  <= 1'b1;
      period_ff <= 14'h0000;
    end else if (sec_tick) begin
      period_ff <= period_done ? 14'h0000 : period_ff + 14'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      long_test_ff <= 1'b0;
      long_ff      <= 10'h000;
    // RULE20 test starts test.
    end else if (period_done || test_entry) begin
      long_test_ff <= 1'b1;
      long_ff      <= 10'h000;
    end else if (long_test_ff && sec_tick) begin
      long_ff      <= long_ff + 10'h001;
      long_test_ff <= !long_done;
    end
  end

  // RULE21 presence check cadence.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pres_ff      <= 6'h00;
      pres_test_ff <= 1'b0;
    end else if (sec_tick) begin
      pres_ff      <= (pres_ff == 6'(kpi_pkg::PRES_PERIOD_S - 1)) ? 6'h00 : pres_ff + 6'h01;
      pres_test_ff <= (pres_ff == 6'(kpi_pkg::PRES_PERIOD_S - 1)) ||
                      (pres_test_ff && pres_ff < 6'(kpi_pkg::PRES_LEN_S - 1));
    end
  end
endmodule

// ==== testbench/kpi_top_props.sv ====
/*
  Concurrent checks on the interpreter's top-level ports.
  Assumes one clock and an asynchronous active-low reset.
*/
module kpi_top_props (
  input wire logic       clk,            // Clock.
  input wire logic       reset_n,        // Reset, active low.
  input wire logic       key_valid,      // Key strobe.
  input wire logic [3:0] key_code,       // Key code.
  input wire logic [4:0] key_addr,       // Keypad address.
  input wire logic       local_prog_dis, // Keypad entry refused.
  input wire logic       test_entry,     // Test mode pulse.
  input wire logic       prog_mode_ff,   // Programming mode.
  input wire logic [1:0] page_ff,        // Field page.
  input wire logic [1:0] page_prefix_ff, // Address prefix.
  input wire logic       alt_banner_ff,  // Page banner.
  input wire logic [7:0] banner_num_ff,  // Banner number.
  input wire logic       beep_ff,        // Beep pulse.
  input wire logic       inst_lock_ff,   // Code lockout.
  input wire logic       long_test_ff    // Long battery test.
);
  localparam int unsigned WIN_CYC = kpi_pkg::PWRUP_WIN_S * kpi_pkg::CLK_HZ;
  logic [30:0] win_cnt_ff;
  logic [30:0] nxt_win_cnt;
  logic        in_win;
  // Counts cycles since reset release and saturates at the end of the window.
  assign in_win      = (win_cnt_ff < 31'(WIN_CYC));
  assign nxt_win_cnt = in_win ? win_cnt_ff + 31'h1 : win_cnt_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_cnt_ff <= 31'h0;
    end else begin
      win_cnt_ff <= nxt_win_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  both_entry_a: assert property (
    key_valid && key_code == kpi_pkg::KEY_BOTH && key_addr <= 5'h01 && in_win
    && !local_prog_dis && !prog_mode_ff |=> prog_mode_ff) else $error("no two-key entry");
  dis_refuse_a: assert property (
    local_prog_dis && !prog_mode_ff |=> !prog_mode_ff) else $error("entry while disabled");
  lock_exit_a: assert property (
    $rose(inst_lock_ff) |-> !prog_mode_ff) else $error("lockout without exit");
  lock_hold_a: assert property (
    inst_lock_ff && !prog_mode_ff && !(key_valid && key_code == kpi_pkg::KEY_BOTH)
    |=> !prog_mode_ff) else $error("entry while locked out");
  page_step_a: assert property (
    $changed(page_ff) && page_ff != 2'h0 |-> page_ff != 2'h3
    && (page_ff == $past(page_ff) + 2'h1 || page_ff == $past(page_ff) - 2'h1))
    else $error("page moved by more than one");
  banner_one_a: assert property (
    page_ff == 2'h1 [*2] |-> alt_banner_ff && banner_num_ff == 8'h10
    && page_prefix_ff == 2'h1) else $error("page two banner wrong");
  banner_two_a: assert property (
    page_ff == 2'h2 [*2] |-> alt_banner_ff && banner_num_ff == 8'h20
    && page_prefix_ff == 2'h2) else $error("page three banner wrong");
  beep_gap_a: assert property (
    beep_ff |=> !beep_ff) else $error("beep longer than one cycle");
  test_start_a: assert property (
    test_entry |-> ##[1:3] long_test_ff) else $error("test mode did not start test");
  cover property (prog_mode_ff && page_ff == 2'h2);
  cover property (beep_ff);
  cover property (inst_lock_ff && !prog_mode_ff);
  cover property (long_test_ff);
endmodule

bind kpi_top kpi_top_props u_props (.clk, .reset_n, .key_valid, .key_code, .key_addr,
  .local_prog_dis, .test_entry, .prog_mode_ff, .page_ff, .page_prefix_ff,
  .alt_banner_ff, .banner_num_ff, .beep_ff, .inst_lock_ff, .long_test_ff);

// ==== testbench/kpi_keypad_model.sv ====
/*
  Behavioural keypad with an installer at it, one key per strobe.
  Assumes the interpreter samples keys on the rising clock edge.
*/
module kpi_keypad_model (
  input  wire logic       clk,       // Clock.
  output logic            key_valid, // Key strobe.
  output logic      [3:0] key_code,  // Key pressed.
  output logic      [4:0] key_addr   // Keypad address.
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    key_valid = 1'b0;
    key_code  = 4'h0;
    key_addr  = 5'h00;
  end
  // Idle lines show the inverse of the last key so stale values never match.
  task automatic press(input logic [3:0] code, input logic [4:0] addr, input int gap);
    @(posedge clk);
    #2;
    key_valid = 1'b1;
    key_code  = code;
    key_addr  = addr;
    @(posedge clk);
    #2;
    key_valid = 1'b0;
    key_code  = ~code;
    key_addr  = ~addr;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// ==== testbench/keypad_program_mode_interpreter_tb_top.sv ====
/*
  Self-checking bench for the keypad programming-mode interpreter.
  Assumes the keypad model drives keys and each reset restarts the power-up window.
*/
module keypad_program_mode_interpreter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, key_valid, local_prog_dis, test_entry, multi_part;
  logic        prog_mode_ff, menu_mode_ff, alt_banner_ff, beep_ff;
  logic        inst_lock_ff, long_test_ff, pres_test_ff;
  logic [1:0]  page_ff, page_prefix_ff;
  logic [2:0]  disp_ff;
  logic [3:0]  key_code, part_field_max, part_ff;
  logic [4:0]  key_addr, kaddr;
  logic [7:0]  banner_num_ff, field_ff;
  logic [15:0] disp_data_ff;
  int          n_mismatch;
  int          checked;
  kpi_top DUT (.clk, .reset_n, .key_valid, .key_code, .key_addr, .local_prog_dis,
    .test_entry, .multi_part, .part_field_max, .prog_mode_ff, .menu_mode_ff, .page_ff,
    .page_prefix_ff, .alt_banner_ff, .banner_num_ff, .field_ff, .disp_ff, .disp_data_ff,
    .part_ff, .beep_ff, .inst_lock_ff, .long_test_ff, .pres_test_ff);
  kpi_keypad_model kp (.clk, .key_valid, .key_code, .key_addr);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // Sends n keys, one hex nibble each, first key in the highest nibble.
  task automatic keys(input logic [31:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      kp.press(s[i*4 +: 4], kaddr, (i == 0) ? 5 : i % 2);
    end
    #2;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    reset_n = 1'b1;
  endtask
  task automatic t_entry();
    do_reset();
    chk(prog_mode_ff, 1'b0);
    keys(32'h0000_000C, 1);
    chk(prog_mode_ff, 1'b1);
    keys(32'h0000_0A99, 3);
    chk({inst_lock_ff, prog_mode_ff}, 2'h0);
    keys(32'h4140_8000, 8);
    chk(prog_mode_ff, 1'b1);
    $display("test entry done");
  endtask
  task automatic t_pages();
    keys(32'h0000_0A94, 3);
    chk({page_ff, page_prefix_ff, alt_banner_ff, banner_num_ff}, 13'h0B10);
    keys(32'h0000_0A94, 3);
    chk({page_ff, page_prefix_ff, alt_banner_ff, banner_num_ff}, 13'h1520);
    keys(32'h0000_0A94, 3);
    chk(page_ff, 2'h2);
    keys(32'h0A24_4321, 7);
    keys(32'h0000_0B24, 3);
    chk(disp_data_ff, 16'h4321);
    keys(32'h00A9_9A99, 6);
    chk({page_ff, alt_banner_ff, prog_mode_ff}, 4'h1);
    $display("test pages done");
  endtask
  task automatic t_fields();
    int nb;
    nb = 0;
    keys(32'h000A_0512, 5);
    keys(32'h0000_0003, 1);
    kp.press(4'h4, kaddr, 0);
    repeat (12) begin
      @(posedge clk);
      #1;
      if (beep_ff === 1'b1) nb++;
    end
    chk(16'(nb), 16'h0003);
    chk(field_ff, 8'h06);
    keys(32'h0000_0B05, 3);
    chk(disp_ff, kpi_pkg::DISP_READ);
    chk(disp_data_ff, 16'h1234);
    multi_part = 1'b1;
    keys(32'h0A05_1234, 7);
    repeat (8) @(posedge clk);
    #2;
    chk(field_ff, 8'h10);
    multi_part = 1'b0;
    $display("test fields done");
  endtask
  task automatic t_errors();
    keys(32'h0000_0A95, 3);
    chk(disp_ff, kpi_pkg::DISP_ADDR_E);
    keys(32'h0000_0B05, 3);
    chk(disp_data_ff, 16'h1234);
    keys(32'h00A9_4A81, 6);
    chk(disp_ff, kpi_pkg::DISP_ADDR_E);
    keys(32'h0000_0A00, 3);
    chk(disp_ff, kpi_pkg::DISP_ADDR_E);
    keys(32'h00A9_4A25, 6);
    chk(disp_ff, kpi_pkg::DISP_ADDR_E);
    keys(32'h00A9_9A99, 6);
    keys(32'h000A_051C, 5);
    chk(disp_ff, kpi_pkg::DISP_BLANK);
    keys(32'h0000_0B05, 3);
    chk(disp_data_ff, 16'h1234);
    $display("test errors done");
  endtask
  task automatic t_cmds();
    keys(32'h0000_0A92, 3);
    chk(disp_ff, kpi_pkg::DISP_REV);
    keys(32'h0000_0A91, 3);
    chk(disp_ff, kpi_pkg::DISP_PART);
    keys(32'h0000_0003, 1);
    chk(part_ff, 4'h3);
    keys(32'h0000_0A93, 3);
    chk(menu_mode_ff, 1'b1);
    $display("test commands done");
  endtask
  task automatic t_lock();
    do_reset();
    keys(32'h0000_0C, 1);
    keys(32'h0000_0A97, 3);
    kaddr = 5'h02;
    keys(32'h0000_0A98, 3);
    chk(prog_mode_ff, 1'b1);
    kaddr = 5'h01;
    keys(32'h0000_0A98, 3);
    chk({inst_lock_ff, prog_mode_ff}, 2'h2);
    keys(32'h4140_8000, 8);
    chk(prog_mode_ff, 1'b0);
    keys(32'h0000_000C, 1);
    chk(prog_mode_ff, 1'b1);
    kaddr = 5'h00;
    $display("test lockout done");
  endtask
  task automatic t_refuse();
    do_reset();
    local_prog_dis = 1'b1;
    keys(32'h0000_000C, 1);
    keys(32'h4140_8000, 8);
    chk(prog_mode_ff, 1'b0);
    local_prog_dis = 1'b0;
    $display("test refusal done");
  endtask
  task automatic t_batt();
    chk({pres_test_ff, long_test_ff}, 2'h0);
    @(posedge clk);
    #2;
    test_entry = 1'b1;
    @(posedge clk);
    #2;
    test_entry = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    chk(long_test_ff, 1'b1);
    $display("test battery done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    reset_n        = 1'b0;
    local_prog_dis = 1'b0;
    test_entry     = 1'b0;
    multi_part     = 1'b0;
    part_field_max = 4'h5;
    kaddr          = 5'h00;
    n_mismatch     = 0;
    checked        = 0;
    t_entry();
    t_pages();
    t_fields();
    t_errors();
    t_cmds();
    t_lock();
    t_refuse();
    t_batt();
    complete_run();
  end
  // The tests need well under two thousand cycles; this allows ten times that.
  initial begin
    #(25 * 20000);
    n_mismatch++;
    complete_run();
  end
endmodule
